// *** src/mtp_consts.svh ***
// offsets, codes and counts for the multichannel timer
// assumes inclusion by the package and the timer only
`ifndef MTP_CONSTS_SVH
`define MTP_CONSTS_SVH
`define MTP_NCH       6
`define MTP_CH_GLOBAL 3'h6
// channel register slots, byte address = ch*0x20 + slot*4
`define MTP_R_CTRL    3'h0
`define MTP_R_IOCTL   3'h1
`define MTP_R_MODE    3'h2
`define MTP_R_COUNT   3'h3
`define MTP_R_GRA     3'h4
// global register slots at 0xC0
`define MTP_G_START   3'h0
`define MTP_G_SYNC    3'h1
`define MTP_G_PINS    3'h2
// prescale_select codes
`define MTP_PSC_DIV1  3'h0
`define MTP_PSC_DIV4  3'h1
`define MTP_PSC_DIV16 3'h2
`define MTP_PSC_DIV64 3'h3
`define MTP_PSC_CASC  3'h7
// clear_source_select codes
`define MTP_CCS_SYNC  3'h3
`define MTP_CCS_A     3'h1
`define MTP_CCS_B     3'h2
`define MTP_CCS_C     3'h5
`define MTP_CCS_D     3'h6
// level_on_match action codes
`define MTP_ACT_NONE  2'h0
`define MTP_ACT_LOW   2'h1
`define MTP_ACT_HIGH  2'h2
`define MTP_ACT_TOG   2'h3
`define MTP_CNT_MAX   16'hFFFF
`endif

// *** src/mtp_pkg.sv ***
// types shared by the multichannel timer
// assumes mtp_consts.svh on the include path
`include "mtp_consts.svh"
package mtp_pkg;
  typedef enum logic [1:0] {MTP_PWM_OFF, MTP_PWM_ONE, MTP_PWM_TWO}
    mtp_pwm_type;
  typedef struct packed {
    logic       capture;     // 1: rising-edge input capture
    logic       init_level;
    logic [1:0] action;
  } mtp_io_type;
  typedef struct packed {
    logic [2:0] clear_source_select;
    logic [2:0] prescale_select;
  } mtp_ctl_type;
  typedef struct packed {
    logic        phase;
    logic        buf_b;
    logic        buf_a;
    mtp_pwm_type pwm;
  } mtp_mode_type;
  typedef struct packed {
    logic [`MTP_NCH-1:0][3:0] level;
    logic [`MTP_NCH-1:0][3:0] oe;
  } mtp_pin_type;
  typedef struct packed {
    logic [`MTP_NCH-1:0][15:0]      cnt;
    logic [`MTP_NCH-1:0][3:0][15:0] gr;
    mtp_ctl_type [`MTP_NCH-1:0]      ctl;
    mtp_io_type [`MTP_NCH-1:0][3:0]  io;
    mtp_mode_type [`MTP_NCH-1:0]     mode;
    logic [`MTP_NCH-1:0]            start;
    logic [`MTP_NCH-1:0]            sync;
    mtp_pin_type                    pins;
    logic [`MTP_NCH-1:0][3:0]       cap_prev;
    logic [`MTP_NCH-1:0][1:0]       enc_prev;
    logic [5:0]                     div;
    logic [31:0]                    prdata;
    logic                           pready;
    logic                           pslverr;
  } mtp_state_type;
endpackage : mtp_pkg

// *** src/mtp_timer.sv ***
// six-channel 16-bit pulse timer unit with an APB register port
// assumes inputs synchronous to clock; pins resolved by the bench
// How it works
// - sync channel count write presets all sync counters
// - sync-clear channels clear with another sync clear
// - all six channels may join synchronous operation
// - buffering on channels 0 and 3: C->A, D->B
// - buffered compare match copies buffer into general
// - buffered capture shifts old general into buffer
// - channels 1:2 and 4:5 cascade into 32 bits
// - upper counts up on lower overflow, down underflow
// - lower underflows only in phase counting mode
// - upper in phase mode ignores cascade clock
// - simultaneous cascaded captures store both halves
// - matches drive low, high or toggle; 0-100% duty
// - pwm per channel; clearing register sets period
// - pwm1 pairs A/B and C/D onto A, C pins
// - pwm1 starts at A/C initial; equal pair holds
// - pwm1 gives up to eight phases on A/C
// - pwm2 period clear returns pins to initial
// - pwm2 duty equal to period leaves pin unchanged
// - pwm2 with sync gives up to fifteen phases
// - pwm2 period pin silent, others own pins
// - match clear restarts count from zero
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "mtp_consts.svh"
module mtp_timer (
  input  wire logic                     clock,      // 10 MHz clock
  input  wire logic                     rst,        // sync, high
  input  wire logic                     psel,       // apb select
  input  wire logic                     penable,    // apb enable
  input  wire logic                     pwrite,     // apb direction
  input  wire logic [11:0]              paddr,      // apb address
  input  wire logic [31:0]              pwdata,     // apb write data
  output logic [31:0]                   prdata,     // apb read data
  output logic                          pready,     // apb ready
  output logic                          pslverr,    // apb error
  input  wire logic [`MTP_NCH-1:0][3:0] capture_in, // pin inputs a-d
  input  wire logic [`MTP_NCH-1:0][1:0] phase_in,   // encoder {b,a}
  output mtp_pkg::mtp_pin_type          pins        // levels, enables
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic apply_level(logic cur, logic [1:0] act);
    unique case (act)
      `MTP_ACT_LOW:  apply_level = 1'b0;
      `MTP_ACT_HIGH: apply_level = 1'b1;
      `MTP_ACT_TOG:  apply_level = ~cur;
      default:       apply_level = cur;
    endcase
  endfunction : apply_level

  function automatic logic presc_tick(logic [2:0] sel, logic [5:0] dv);
    unique case (sel)
      `MTP_PSC_DIV1:  presc_tick = 1'b1;
      `MTP_PSC_DIV4:  presc_tick = (dv[1:0] == 2'h0);
      `MTP_PSC_DIV16: presc_tick = (dv[3:0] == 4'h0);
      `MTP_PSC_DIV64: presc_tick = (dv == 6'h00);
      default:        presc_tick = 1'b0;
    endcase
  endfunction : presc_tick

  // channels 0 and 3 own registers c and d
  function automatic logic has_cd(int c);
    has_cd = (c == 0) || (c == 3);
  endfunction : has_cd

  function automatic logic has_phase(int c);
    has_phase = !has_cd(c);
  endfunction : has_phase

  // {valid, index} of the general register a clear source names
  function automatic logic [2:0] ccs_reg(logic [2:0] ccs);
    unique case (ccs)
      `MTP_CCS_A: ccs_reg = 3'h4;
      `MTP_CCS_B: ccs_reg = 3'h5;
      `MTP_CCS_C: ccs_reg = 3'h6;
      `MTP_CCS_D: ccs_reg = 3'h7;
      default:    ccs_reg = 3'h0;
    endcase
  endfunction : ccs_reg

  function automatic logic mapped(logic [2:0] chn, logic [2:0] rg);
    if (chn == `MTP_CH_GLOBAL) begin
      mapped = (rg <= `MTP_G_PINS);
    end else if (chn < 3'(`MTP_NCH)) begin
      mapped = (rg < 3'h6) || has_cd(int'(chn));
    end else begin
      mapped = 1'b0;
    end
  endfunction : mapped

  function automatic logic [31:0] read_reg(mtp_pkg::mtp_state_type s,
                                           logic [2:0] chn,
                                           logic [2:0] rg);
    read_reg = 32'h0;
    if (chn == `MTP_CH_GLOBAL) begin
      unique case (rg)
        `MTP_G_START: read_reg = {26'h0, s.start};
        `MTP_G_SYNC:  read_reg = {26'h0, s.sync};
        default:      read_reg = {8'h0, s.pins.level};
      endcase
    end else begin
      unique case (rg)
        `MTP_R_CTRL:  read_reg = {26'h0, s.ctl[chn]};
        `MTP_R_IOCTL: read_reg = {16'h0, s.io[chn]};
        `MTP_R_MODE:  read_reg = {27'h0, s.mode[chn]};
        `MTP_R_COUNT: read_reg = {16'h0, s.cnt[chn]};
        default:      read_reg = {16'h0, s.gr[chn][rg[1:0]]};
      endcase
    end
  endfunction : read_reg

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mtp_pkg::mtp_state_type   st_q;
  mtp_pkg::mtp_state_type   st_d;
  logic [`MTP_NCH-1:0]      tick;
  logic [`MTP_NCH-1:0]      up;
  logic [`MTP_NCH-1:0]      ovf;
  logic [`MTP_NCH-1:0]      unf;
  logic [`MTP_NCH-1:0]      clr_own;
  logic [`MTP_NCH-1:0]      clr;
  logic [`MTP_NCH-1:0][3:0] match;
  logic [`MTP_NCH-1:0][3:0] cap;
  logic                     any_sync_clr;
  logic                     wr;
  logic                     acc;
  logic [2:0]               chn;
  logic [2:0]               rg;

  always_comb begin
    logic       a_chg;
    logic       b_chg;
    logic       bufd;
    logic [2:0] pr;
    logic       lvl;
    st_d = st_q;
    a_chg = 1'b0;
    b_chg = 1'b0;
    bufd = 1'b0;
    pr = 3'h0;
    lvl = 1'b0;
    tick = '0;
    up = '0;
    ovf = '0;
    unf = '0;
    match = '0;
    cap = '0;
    clr_own = '0;
    clr = '0;
    any_sync_clr = 1'b0;
    st_d.div = st_q.div + 6'h01;
    // --------------------------------------------------------------
    // count clocks; walk downward so lower halves settle first
    // --------------------------------------------------------------
    for (int c = `MTP_NCH - 1; c >= 0; c--) begin
      if (has_phase(c) && st_q.mode[c].phase) begin
        a_chg = phase_in[c][0] ^ st_q.enc_prev[c][0];
        b_chg = phase_in[c][1] ^ st_q.enc_prev[c][1];
        tick[c] = a_chg ^ b_chg;
        up[c] = phase_in[c][0] ^ st_q.enc_prev[c][1];
      end else if ((c == 1 || c == 4) &&
          st_q.ctl[c].prescale_select == `MTP_PSC_CASC) begin
        tick[c] = ovf[c+1] | unf[c+1];
        up[c] = ovf[c+1];
      end else begin
        tick[c] = presc_tick(st_q.ctl[c].prescale_select, st_q.div);
        up[c] = 1'b1;
      end
      tick[c] = tick[c] & st_q.start[c];
      ovf[c] = tick[c] & up[c] & (st_q.cnt[c] == `MTP_CNT_MAX);
      unf[c] = tick[c] & ~up[c] & (st_q.cnt[c] == 16'h0000);
    end
    // --------------------------------------------------------------
    // compare matches, captures and clear sources
    // --------------------------------------------------------------
    for (int c = 0; c < `MTP_NCH; c++) begin
      st_d.enc_prev[c] = phase_in[c];
      st_d.cap_prev[c] = capture_in[c];
      for (int r = 0; r < 4; r++) begin
        bufd = (r >= 2) && (r == 2 ? st_q.mode[c].buf_a
                                   : st_q.mode[c].buf_b);
        if ((r < 2 || has_cd(c)) && !bufd) begin
          if (st_q.io[c][r].capture) begin
            cap[c][r] = capture_in[c][r] & ~st_q.cap_prev[c][r];
          end else begin
            match[c][r] = tick[c] & (st_q.cnt[c] == st_q.gr[c][r]);
          end
        end
      end
      pr = ccs_reg(st_q.ctl[c].clear_source_select);
      clr_own[c] = pr[2] &
                   (match[c][pr[1:0]] | cap[c][pr[1:0]]);
      any_sync_clr = any_sync_clr | (st_q.sync[c] & clr_own[c]);
    end
    for (int c = 0; c < `MTP_NCH; c++) begin
      clr[c] = clr_own[c] | (st_q.sync[c] & any_sync_clr &
               (st_q.ctl[c].clear_source_select == `MTP_CCS_SYNC));
      if (clr[c]) begin
        st_d.cnt[c] = 16'h0000;
      end else if (tick[c]) begin
        st_d.cnt[c] = up[c] ? st_q.cnt[c] + 16'h0001
                            : st_q.cnt[c] - 16'h0001;
      end
      for (int r = 0; r < 2; r++) begin
        bufd = has_cd(c) && (r == 0 ? st_q.mode[c].buf_a
                                    : st_q.mode[c].buf_b);
        if (cap[c][r]) begin
          st_d.gr[c][r] = st_q.cnt[c];
          if (bufd) begin
            st_d.gr[c][r+2] = st_q.gr[c][r];
          end
        end else if (match[c][r] && bufd) begin
          st_d.gr[c][r] = st_q.gr[c][r+2];
        end
      end
      for (int r = 2; r < 4; r++) begin
        if (cap[c][r]) begin
          st_d.gr[c][r] = st_q.cnt[c];
        end
      end
      // ------------------------------------------------------------
      // waveform pins
      // ------------------------------------------------------------
      for (int r = 0; r < 4; r++) begin
        st_d.pins.oe[c][r] = 1'b0;
      end
      if (!st_q.start[c]) begin
        for (int r = 0; r < 4; r++) begin
          st_d.pins.level[c][r] = st_q.io[c][r].init_level;
        end
      end
      unique case (st_q.mode[c].pwm)
        mtp_pkg::MTP_PWM_ONE: begin
          // pairs a/b and c/d drive pins a and c
          for (int p = 0; p < 4; p += 2) begin
            if (p == 0 || has_cd(c)) begin
              st_d.pins.oe[c][p] = !st_q.io[c][p].capture;
              lvl = st_q.start[c] ? st_q.pins.level[c][p]
                                  : st_q.io[c][p].init_level;
              if (st_q.gr[c][p] != st_q.gr[c][p+1]) begin
                if (match[c][p]) begin
                  lvl = apply_level(lvl, st_q.io[c][p].action);
                end
                if (match[c][p+1]) begin
                  lvl = apply_level(lvl, st_q.io[c][p+1].action);
                end
              end
              st_d.pins.level[c][p] = lvl;
            end
          end
        end
        mtp_pkg::MTP_PWM_TWO: begin
          pr = ccs_reg(st_q.ctl[c].clear_source_select);
          for (int r = 0; r < 4; r++) begin
            if ((r < 2 || has_cd(c)) && !(pr[2] && pr[1:0] == r)) begin
              st_d.pins.oe[c][r] = !st_q.io[c][r].capture;
              if (clr[c]) begin
                st_d.pins.level[c][r] = st_q.io[c][r].init_level;
              end else if (match[c][r] && !(pr[2] &&
                  st_q.gr[c][r] == st_q.gr[c][pr[1:0]])) begin
                st_d.pins.level[c][r] = apply_level(
                  st_q.pins.level[c][r], st_q.io[c][r].action);
              end
            end
          end
        end
        default: begin
          for (int r = 0; r < 4; r++) begin
            if (r < 2 || has_cd(c)) begin
              st_d.pins.oe[c][r] = !st_q.io[c][r].capture &&
                (st_q.io[c][r].action != `MTP_ACT_NONE);
              if (match[c][r]) begin
                st_d.pins.level[c][r] = apply_level(
                  st_q.pins.level[c][r], st_q.io[c][r].action);
              end
            end
          end
        end
      endcase
    end
    // --------------------------------------------------------------
    // apb slave: one wait state, write at the ready edge
    // --------------------------------------------------------------
    acc = psel & penable;
    chn = paddr[7:5];
    rg = paddr[4:2];
    wr = acc & st_q.pready & pwrite & mapped(chn, rg);
    st_d.pready = acc & ~st_q.pready;
    st_d.pslverr = acc & ~st_q.pready & ~mapped(chn, rg);
    st_d.prdata = (acc && !st_q.pready && !pwrite && mapped(chn, rg))
                  ? read_reg(st_q, chn, rg) : 32'h0;
    if (wr && chn == `MTP_CH_GLOBAL) begin
      if (rg == `MTP_G_START) begin
        st_d.start = pwdata[5:0];
      end else if (rg == `MTP_G_SYNC) begin
        st_d.sync = pwdata[5:0];
      end
    end else if (wr) begin
      unique case (rg)
        `MTP_R_CTRL:  st_d.ctl[chn] = pwdata[5:0];
        `MTP_R_IOCTL: st_d.io[chn] = pwdata[15:0];
        `MTP_R_MODE: begin
          st_d.mode[chn].pwm = mtp_pkg::mtp_pwm_type'(pwdata[1:0]);
          st_d.mode[chn].buf_a = pwdata[2] & has_cd(int'(chn));
          st_d.mode[chn].buf_b = pwdata[3] & has_cd(int'(chn));
          st_d.mode[chn].phase = pwdata[4] & has_phase(int'(chn));
        end
        `MTP_R_COUNT: begin
          // software wins over a count or clear in the same cycle
          for (int c = 0; c < `MTP_NCH; c++) begin
            if (c == int'(chn) || (st_q.sync[chn] && st_q.sync[c])) begin
              st_d.cnt[c] = pwdata[15:0];
            end
          end
        end
        default: st_d.gr[chn][rg[1:0]] = pwdata[15:0];
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign pins = st_q.pins;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic preset_sync;
  assign preset_sync = wr && chn == 3'h5 && rg == `MTP_R_COUNT &&
                       st_q.sync[5] && st_q.sync[1];

  sync_preset_a: assert property (preset_sync |=>
    st_q.cnt[1] == $past(pwdata[15:0]) && st_q.cnt[5] == st_q.cnt[1])
    else $error("sync preset missed a channel");
  sync_clear_a: assert property (
    any_sync_clr && st_q.sync[1] && !wr &&
    st_q.ctl[1].clear_source_select == `MTP_CCS_SYNC |=>
    st_q.cnt[1] == 16'h0000)
    else $error("sync clear missed");
  buf_cmp_a: assert property (
    match[0][0] && st_q.mode[0].buf_a && !wr |=>
    st_q.gr[0][0] == $past(st_q.gr[0][2]))
    else $error("compare buffer not transferred");
  buf_cap_a: assert property (
    cap[3][0] && st_q.mode[3].buf_a && !wr |=>
    st_q.gr[3][2] == $past(st_q.gr[3][0]) &&
    st_q.gr[3][0] == $past(st_q.cnt[3]))
    else $error("capture buffer shift wrong");
  casc_up_a: assert property (
    ovf[2] && st_q.start[1] && !st_q.mode[1].phase && !clr[1] && !wr &&
    st_q.ctl[1].prescale_select == `MTP_PSC_CASC |=>
    st_q.cnt[1] == $past(st_q.cnt[1]) + 16'h0001)
    else $error("upper half missed overflow");
  no_unf_a: assert property (!st_q.mode[2].phase |-> !unf[2])
    else $error("underflow outside phase mode");
  match_clr_a: assert property (
    match[1][1] && !wr &&
    st_q.ctl[1].clear_source_select == `MTP_CCS_B |=>
    st_q.cnt[1] == 16'h0000 ##1 st_q.cnt[1] <= 16'h0001)
    else $error("match clear failed");
  pwm1_hold_a: assert property (
    st_q.start[0] && st_q.mode[0].pwm == mtp_pkg::MTP_PWM_ONE &&
    st_q.gr[0][0] == st_q.gr[0][1] |=> $stable(st_q.pins.level[0][0]))
    else $error("pwm1 equal pair moved pin");
  pwm2_init_a: assert property (
    clr[1] && st_q.mode[1].pwm == mtp_pkg::MTP_PWM_TWO &&
    st_q.ctl[1].clear_source_select == `MTP_CCS_B |=>
    st_q.pins.level[1][0] == $past(st_q.io[1][0].init_level) &&
    !st_q.pins.oe[1][1])
    else $error("pwm2 clear level or period pin wrong");
  apb_ready_a: assert property (psel && penable && !pready |=>
    pready ##1 !pready)
    else $error("apb answer timing wrong");

  sync_preset_c: cover property (preset_sync);
  casc_ovf_c: cover property (ovf[2] && st_q.start[1]);
  pwm2_clr_c: cover property (clr[1] &&
    st_q.mode[1].pwm == mtp_pkg::MTP_PWM_TWO);
  buf_cap_c: cover property (cap[3][0] && st_q.mode[3].buf_a);
endmodule : mtp_timer

// *** tb/mtp_pin_model.sv ***
// pin-side model: capture sources, encoder lines, resolved output pins
// assumes the bench raises cap_req for one cycle per rising edge wanted
`timescale 1ns/1ps
module mtp_pin_model (
  input  wire logic                 clock,      // timer clock
  input  wire logic                 rst,        // sync, high
  input  wire logic [5:0][3:0]      cap_req,    // edge requests
  input  wire logic [5:0][1:0]      phase_req,  // encoder drive
  input  wire mtp_pkg::mtp_pin_type pins,       // device pin drive
  output logic [5:0][3:0]           capture_in, // to device
  output logic [5:0][1:0]           phase_in,   // encoder lines
  output logic [5:0][3:0]           pin_wire    // resolved levels
);
  // --------------------------------------------------------------
  // pins
  // --------------------------------------------------------------
  // undriven pins sit on a pull-down, so a missing enable reads 0
  assign pin_wire = pins.level & pins.oe;
  // encoder lines follow the bench's drive, resting low
  assign phase_in = phase_req;
  // capture lines change only after an edge, like a synced source
  always_ff @(posedge clock) begin
    if (rst) begin
      capture_in <= '0;
    end else begin
      capture_in <= cap_req;
    end
  end
endmodule : mtp_pin_model

// *** tb/multichannel_timer_pwm_modes_tb_top.sv ***
// self-checking bench for the timer: apb master, scenarios, verdict
// assumes mtp_timer and mtp_pin_model; apb answers with one wait state
`timescale 1ns/1ps
module multichannel_timer_pwm_modes_tb_top;
  logic                 clock = 1'b0;
  logic                 rst = 1'b1;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [11:0]          paddr = '0;
  logic [31:0]          pwdata = '0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic [5:0][3:0]      cap_req = '0;
  logic [5:0][1:0]      phase_req = '0;
  logic [5:0][3:0]      capture_in;
  logic [5:0][1:0]      phase_in;
  logic [5:0][3:0]      pin_wire;
  mtp_pkg::mtp_pin_type pins;
  int                   mismatches = 0;
  int                   tests_run = 0;
  int                   cycles = 0;
  logic [31:0]          rd;
  logic                 er;

  mtp_timer mtp_timer_inst (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_in(capture_in), .phase_in(phase_in), .pins(pins));
  mtp_pin_model mtp_pin_model_inst (.clock(clock), .rst(rst),
    .cap_req(cap_req), .pins(pins), .capture_in(capture_in),
    .phase_req(phase_req), .phase_in(phase_in), .pin_wire(pin_wire));

  always #50 clock = ~clock;

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  // the whole run needs under a thousand cycles; a hang stops here
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic [11:0] ra(int ch, int slot);
    return 12'(ch * 32 + slot * 4);
  endfunction : ra

  // one transfer; entered just after an edge, leaves one idle cycle
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic wr(logic [11:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rc(string nm, logic [11:0] a, logic [31:0] exp);
    apb(1'b0, a, '0);
    chk(nm, rd, exp);
  endtask : rc

  task automatic reset_dut();
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
  endtask : reset_dut

  task automatic cap(logic [5:0][3:0] m);
    cap_req <= m;
    @(posedge clock);
    cap_req <= '0;
    repeat (4) @(posedge clock);
  endtask : cap

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_map();
    rc("count0 at reset", ra(0, 3), 32'h0);
    apb(1'b0, ra(1, 6), '0);
    chk("gr c of ch1 refused", {31'h0, er}, 32'h1);
    chk("gr c of ch1 data", rd, 32'h0);
  endtask : t_map

  task automatic t_sync();
    reset_dut();
    wr(12'hC4, 32'h3E);
    wr(ra(5, 3), 32'h1234);
    for (int c = 0; c < 6; c++) begin
      rc($sformatf("count%0d", c), ra(c, 3),
         c == 0 ? 32'h0 : 32'h1234);
    end
  endtask : t_sync

  task automatic t_sync_clear();
    logic [31:0] c0;
    reset_dut();
    wr(ra(0, 0), 32'h08);
    wr(ra(1, 0), 32'h18);
    wr(ra(0, 4), 32'h9);
    wr(12'hC4, 32'h03);
    wr(12'hC0, 32'h03);
    repeat (37) @(posedge clock);
    wr(12'hC0, 32'h0);
    apb(1'b0, ra(0, 3), '0);
    c0 = rd;
    // 41 ticks ran with a period of ten, so both counts end on one
    chk("count0 wrapped by period", c0, 32'h1);
    rc("count1 cleared with count0", ra(1, 3), 32'h1);
  endtask : t_sync_clear

  task automatic t_buf_cmp();
    reset_dut();
    wr(ra(0, 0), 32'h08);
    wr(ra(0, 2), 32'h04);
    wr(ra(0, 4), 32'h5);
    wr(ra(0, 6), 32'h14);
    rc("gr a before match", ra(0, 4), 32'h5);
    wr(12'hC0, 32'h01);
    repeat (10) @(posedge clock);
    rc("gr a first transfer", ra(0, 4), 32'h14);
    wr(ra(0, 6), 32'h8);
    repeat (40) @(posedge clock);
    rc("gr a second transfer", ra(0, 4), 32'h8);
  endtask : t_buf_cmp

  task automatic t_buf_cap();
    reset_dut();
    wr(ra(3, 1), 32'h8);
    wr(ra(3, 2), 32'h04);
    wr(ra(3, 0), 32'h04);
    wr(12'hC0, 32'h08);
    wr(ra(3, 3), 32'h111);
    cap(24'h001000);
    rc("gr a capture 1", ra(3, 4), 32'h111);
    rc("gr c capture 1", ra(3, 6), 32'h0);
    wr(ra(3, 3), 32'h222);
    cap(24'h001000);
    rc("gr a capture 2", ra(3, 4), 32'h222);
    rc("gr c capture 2", ra(3, 6), 32'h111);
  endtask : t_buf_cap

  task automatic t_cascade();
    reset_dut();
    wr(ra(1, 0), 32'h07);
    wr(ra(1, 1), 32'h8);
    wr(ra(2, 1), 32'h8);
    wr(ra(2, 3), 32'hFFF8);
    wr(12'hC0, 32'h06);
    repeat (30) @(posedge clock);
    wr(12'hC0, 32'h0);
    rc("upper after one overflow", ra(1, 3), 32'h1);
    wr(ra(1, 3), 32'h1234);
    wr(ra(2, 3), 32'hABCD);
    cap(24'h000110);
    rc("upper capture", ra(1, 4), 32'h1234);
    rc("lower capture", ra(2, 4), 32'hABCD);
  endtask : t_cascade

  task automatic t_phase();
    reset_dut();
    wr(ra(1, 0), 32'h07);
    wr(ra(2, 2), 32'h10);
    wr(12'hC0, 32'h06);
    phase_req[2] <= 2'h2;
    repeat (3) @(posedge clock);
    rc("lower after down step", ra(2, 3), 32'hFFFF);
    rc("upper after underflow", ra(1, 3), 32'hFFFF);
    wr(ra(1, 2), 32'h10);
    phase_req[2] <= 2'h0;
    repeat (3) @(posedge clock);
    rc("lower after up step", ra(2, 3), 32'h0);
    rc("upper in phase mode", ra(1, 3), 32'hFFFF);
  endtask : t_phase

  task automatic t_pwm(int ch, logic [31:0] ctl, logic [31:0] io,
                       logic [31:0] md, logic [31:0] ga, logic [31:0] gb,
                       logic [31:0] exp);
    logic [31:0] h;
    reset_dut();
    wr(ra(ch, 0), ctl);
    wr(ra(ch, 1), io);
    wr(ra(ch, 2), md);
    wr(ra(ch, 4), ga);
    wr(ra(ch, 5), gb);
    wr(12'hC0, 32'h1 << ch);
    repeat (25) @(posedge clock);
    h = 0;
    repeat (40) begin
      @(posedge clock);
      h = h + pin_wire[ch][0];
    end
    chk("pin a high cycles", h, exp);
    chk("pin a enabled", {31'h0, pins.oe[ch][0]}, 32'h1);
    chk("pin b silent", {31'h0, pins.oe[ch][1]}, 32'h0);
  endtask : t_pwm

  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_map();
    t_sync();
    t_sync_clear();
    t_buf_cmp();
    t_buf_cap();
    t_cascade();
    t_phase();
    t_pwm(0, 32'h08, 32'h21, 32'h1, 32'h9, 32'h4, 32'd20);
    t_pwm(0, 32'h08, 32'h21, 32'h1, 32'h9, 32'h9, 32'd0);
    t_pwm(1, 32'h10, 32'h32, 32'h2, 32'h3, 32'h9, 32'd24);
    t_pwm(1, 32'h10, 32'h32, 32'h2, 32'h9, 32'h9, 32'd0);
    finish_test();
  end
endmodule : multichannel_timer_pwm_modes_tb_top
